/* design/ds3_elastic_mem.sv */
// one-bit wide elastic store memory with registered, write-through read
`timescale 1ns/1ps

module ds3_elastic_mem #(
	parameter int DEPTH = 64,
	parameter int AW    = 6
)(
	input  wire logic          ref_clk,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic          wr_bit,
	input  wire logic [AW-1:0] rd_addr,
	output logic               rd_bit
);
	// ==========================================================
	// elaboration checks
	generate
		if (DEPTH < 4 || (1 << AW) != DEPTH)
			$error("elastic depth must be a power of two matching the address width");
	endgenerate

	// ==========================================================
	// storage
	logic mem [DEPTH];

	// write-through so a bit written this edge is readable at once
	always_ff @(posedge ref_clk)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_bit;
		if (wr_en && wr_addr == rd_addr)
			rd_bit <= wr_bit;
		else
			rd_bit <= mem[rd_addr];
	end

endmodule

/* design/ds3_map_pkg.sv */
// shared constants and row layout table for the ds3 to envelope mapper
package ds3_map_pkg;

	// ==========================================================
	// envelope geometry
	localparam int ROWS            = 9;
	localparam int POH_BITS        = 8;     // one path overhead byte per row
	localparam int COLS_PER_ROW    = 87;
	localparam int BITS_PER_ROW    = COLS_PER_ROW * 8;
	localparam int DATA_PER_ROW    = 621;
	localparam int DATA_PER_ENV    = 5589;
	localparam int CTRL_PER_ROW    = 5;
	localparam int FIXED_PER_ROW   = 59;
	localparam int OHC_PER_ROW     = 2;
	localparam int SOPP_PER_ROW    = 1;
	localparam int SEG_COUNT       = 15;

	// ==========================================================
	// rates and envelope content, nominal and surplus
	localparam int DS3_RATE_BPS    = 44736000;
	localparam int STS1_CLK_HZ     = 51840000;
	localparam int REF_CLK_HZ      = 40000000;
	localparam int ENV_PER_SEC     = 8000;
	localparam int DS3_PER_ENV_NOM = DS3_RATE_BPS / ENV_PER_SEC;   // 5592
	localparam int DS3_PER_ENV_NEG = 5593;
	localparam int SOPP_DATA_NOM   = 3;
	localparam int SOPP_JUNK_NOM   = 6;
	localparam int SOPP_DATA_NEG   = 4;
	localparam int SOPP_JUNK_NEG   = 5;
	localparam int DS3_PPM_MAX     = 20;
	localparam int STS1_PPM_S3     = 46;    // tenths of a ppm, 4.6 ppm
	localparam int STS1_PPM_MIN    = 20;

	// ==========================================================
	// elastic store defaults
	localparam int ELASTIC_DEPTH   = 64;
	localparam int ELASTIC_THRESH  = 32;

	// ==========================================================
	// bit kinds within a row
	typedef enum logic [2:0]
	{
		K_POH   = 3'h0,
		K_FIXED = 3'h1,
		K_CTRL  = 3'h2,
		K_DATA  = 3'h3,
		K_OHC   = 3'h4,
		K_SOPP  = 3'h5
	} seg_kind_e;

	// row layout, left to right
	localparam seg_kind_e SEG_KIND [SEG_COUNT] = '{
		K_POH, K_FIXED, K_CTRL, K_DATA, K_FIXED, K_CTRL, K_FIXED, K_DATA,
		K_FIXED, K_CTRL, K_FIXED, K_OHC, K_FIXED, K_SOPP, K_DATA};
	localparam logic [7:0] SEG_LEN [SEG_COUNT] = '{
		8'h08, 8'h12, 8'h01, 8'hcd, 8'h10, 8'h02, 8'h06, 8'hd0,
		8'h10, 8'h02, 8'h02, 8'h02, 8'h01, 8'h01, 8'hd0};

	localparam logic [3:0] LAST_SEG = 4'he;
	localparam logic [3:0] LAST_ROW = 4'h8;

endpackage

/* design/ds3_spe_mapper.sv */
// asynchronous ds3 to envelope bit mapper with per-row stuffing decision
`timescale 1ns/1ps

// Summary of operation
// - 621 data bits per row, 5589 per envelope
// - one stuff opportunity per row, data or junk
// - five control bits per row
// - opportunity carries data: control bits all zero
// - opportunity carries junk: control bits all one
// - two overhead communication bits, filler value
// - one envelope per frame, 8000 per second
// - nominal: 5592 bits, three data opportunities
// - nominal rates 44.736 Mbit/s and 51.84 MHz
// - decision follows accumulated clock difference
// - surplus bits: 5593 bits, four data opportunities
// - 1 ppm fast: extra bit every 178.8 envelopes
// - tolerate 20 ppm ds3, 4.6/20 ppm clock
// - ds3 bits carried transparently, overhead included
// - 87 columns by 9 rows, first column overhead
// - 59 fixed filler bits per row
module ds3_spe_mapper
	import ds3_map_pkg::*;
#(
	parameter int DEPTH  = ds3_map_pkg::ELASTIC_DEPTH,
	parameter int THRESH = ds3_map_pkg::ELASTIC_THRESH
)(
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	input  wire logic ds3_bit,
	input  wire logic ds3_valid,
	output logic      ds3_ready,
	input  wire logic spe_ready,
	output logic      spe_bit,
	output logic      spe_valid,
	output logic      spe_poh,
	output logic      spe_first,
	output logic      row_sopp_data,
	output logic      elastic_overflow,
	output logic      elastic_underrun
);
	import ds3_map_pkg::*;

	localparam int AW = $clog2(DEPTH);
	localparam int FW = AW + 1;
	localparam logic [FW-1:0] FILL_FULL   = FW'(DEPTH);
	localparam logic [FW-1:0] FILL_THRESH = FW'(THRESH);

	// ==========================================================
	// elaboration checks
	generate
		if (THRESH < 2 || THRESH > DEPTH - 2)
			$error("threshold must leave room on both sides of the store");
	endgenerate

	typedef enum logic [1:0]
	{
		ST_FILL = 2'b01,
		ST_RUN  = 2'b10
	} map_state_e;

	// ==========================================================
	// state
	map_state_e      state_r,    state_nxt;
	logic [3:0]      seg_idx_r,  seg_idx_nxt;
	logic [7:0]      seg_cnt_r,  seg_cnt_nxt;
	logic [3:0]      row_r,      row_nxt;
	logic            junk_r,     junk_nxt;
	logic [AW-1:0]   wr_ptr_r,   wr_ptr_nxt;
	logic [AW-1:0]   rd_ptr_r,   rd_ptr_nxt;
	logic [FW-1:0]   fill_r,     fill_nxt;
	logic            ready_r,    ready_nxt;
	logic            bit_r,      bit_nxt;
	logic            valid_r,    valid_nxt;
	logic            poh_r,      poh_nxt;
	logic            first_r,    first_nxt;
	logic            ovf_r,      ovf_nxt;
	logic            unf_r,      unf_nxt;
	logic            sopp_r,     sopp_nxt;

	seg_kind_e       kind;
	logic            advance;
	logic            want_data;
	logic            push;
	logic            pop;
	logic            store_bit;

	// ==========================================================
	// elastic store; its fill level is the running clock difference
	ds3_elastic_mem #(
		.DEPTH   (DEPTH),
		.AW      (AW)
	) u_mem (
		.ref_clk (ref_clk),
		.wr_en   (push),
		.wr_addr (wr_ptr_r),
		.wr_bit  (ds3_bit),
		.rd_addr (rd_ptr_nxt),
		.rd_bit  (store_bit)
	);

	// ==========================================================
	// next-state logic for row walk, stuffing and store pointers
	always_comb
	begin
		state_nxt   = state_r;
		seg_idx_nxt = seg_idx_r;
		seg_cnt_nxt = seg_cnt_r;
		row_nxt     = row_r;
		junk_nxt    = junk_r;
		bit_nxt     = 1'b0;
		poh_nxt     = 1'b0;
		first_nxt   = 1'b0;
		kind        = SEG_KIND[seg_idx_r];
		advance     = (state_r == ST_RUN) && spe_ready;
		valid_nxt   = advance;

		// data slots plus an opportunity that was chosen for data
		want_data   = advance && ((kind == K_DATA) || (kind == K_SOPP && !junk_r));
		push        = ds3_valid && ready_r;
		pop         = want_data && (fill_r != '0);
		unf_nxt     = want_data && (fill_r == '0);
		ovf_nxt     = ds3_valid && !ready_r;

		// starting on a half-full store gives the widest offset margin
		case (state_r)
			ST_FILL:
			begin
				if (fill_r >= FILL_THRESH)
					state_nxt = ST_RUN;
			end
			ST_RUN:
			begin
				if (advance)
				begin
					// decide the row's opportunity before its control bits go out
					if (seg_idx_r == '0 && seg_cnt_r == '0)
					begin
						// surplus bits above the mark pull in an extra data bit
						junk_nxt  = (fill_r < FILL_THRESH);
						first_nxt = (row_r == '0);
					end
					case (kind)
						K_POH:   poh_nxt = 1'b1;
						K_CTRL:  bit_nxt = (seg_idx_r == '0) ? junk_nxt : junk_r;
						K_DATA:  bit_nxt = store_bit;
						K_SOPP:  bit_nxt = junk_r ? 1'b0 : store_bit;
						// filler and comms bits carry no meaning; send zero
						K_FIXED: bit_nxt = 1'b0;
						K_OHC:   bit_nxt = 1'b0;
						default: bit_nxt = 1'b0;
					endcase
					// walk segments, rows and envelopes
					if (seg_cnt_r == SEG_LEN[seg_idx_r] - 8'h01)
					begin
						seg_cnt_nxt = '0;
						if (seg_idx_r == LAST_SEG)
						begin
							seg_idx_nxt = '0;
							row_nxt     = (row_r == LAST_ROW) ? 4'h0 : row_r + 4'h1;
						end
						else
							seg_idx_nxt = seg_idx_r + 4'h1;
					end
					else
						seg_cnt_nxt = seg_cnt_r + 8'h01;
				end
			end
			default:
				state_nxt = ST_FILL;
		endcase

		// opportunity flag kept in its own flop so the port needs no gate
		sopp_nxt   = ~junk_nxt;
		wr_ptr_nxt = push ? wr_ptr_r + AW'(1) : wr_ptr_r;
		rd_ptr_nxt = pop  ? rd_ptr_r + AW'(1) : rd_ptr_r;
		fill_nxt   = fill_r + FW'(push) - FW'(pop);
		// registered ready still leaves one free slot for the next push
		ready_nxt  = (fill_nxt < FILL_FULL - FW'(1)) || ((fill_nxt == FILL_FULL - FW'(1)) && !push);
	end

	// ==========================================================
	// registers
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_r   <= ST_FILL;
			seg_idx_r <= '0;
			seg_cnt_r <= '0;
			row_r     <= '0;
			junk_r    <= 1'b1;
			wr_ptr_r  <= '0;
			rd_ptr_r  <= '0;
			fill_r    <= '0;
			ready_r   <= 1'b0;
			bit_r     <= 1'b0;
			valid_r   <= 1'b0;
			poh_r     <= 1'b0;
			first_r   <= 1'b0;
			ovf_r     <= 1'b0;
			unf_r     <= 1'b0;
			sopp_r    <= 1'b0;
		end
		else
		begin
			state_r   <= state_nxt;
			seg_idx_r <= seg_idx_nxt;
			seg_cnt_r <= seg_cnt_nxt;
			row_r     <= row_nxt;
			junk_r    <= junk_nxt;
			wr_ptr_r  <= wr_ptr_nxt;
			rd_ptr_r  <= rd_ptr_nxt;
			fill_r    <= fill_nxt;
			ready_r   <= ready_nxt;
			bit_r     <= bit_nxt;
			valid_r   <= valid_nxt;
			poh_r     <= poh_nxt;
			first_r   <= first_nxt;
			ovf_r     <= ovf_nxt;
			unf_r     <= unf_nxt;
			sopp_r    <= sopp_nxt;
		end
	end

	// ==========================================================
	// outputs, all straight from flops
	assign ds3_ready        = ready_r;
	assign spe_bit          = bit_r;
	assign spe_valid        = valid_r;
	assign spe_poh          = poh_r;
	assign spe_first        = first_r;
	assign row_sopp_data    = sopp_r;
	assign elastic_overflow = ovf_r;
	assign elastic_underrun = unf_r;

endmodule

/* verif/ds3_map_chk_sva.sv */
// port checker for the ds3 envelope mapper
`timescale 1ns/1ps
module ds3_map_chk (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic ds3_valid,
	input wire logic ds3_ready,
	input wire logic spe_ready,
	input wire logic spe_bit,
	input wire logic spe_valid,
	input wire logic spe_poh,
	input wire logic spe_first,
	input wire logic row_sopp_data,
	input wire logic elastic_overflow
);
	int pos_r, pos_nxt, cur, kind;
	// ====
	// slot in the row; the envelope mark restarts it
	always_comb
	begin
		cur = spe_first ? 0 : pos_r;
		pos_nxt = spe_valid ? (cur + 1) % 696 : pos_r;
		kind = 2;
		if (cur < 27 || cur > 231 && cur < 256 || cur > 463 && cur < 487)
			kind = 0;
		if (cur == 26 || cur == 248 || cur == 249 || cur == 480 || cur == 481)
			kind = 1;
		if (cur == 487)
			kind = 3;
	end
	always_ff @(posedge ref_clk or posedge sys_rst)
		if (sys_rst)
			pos_r <= 0;
		else
			pos_r <= pos_nxt;
	// ====
	// port relations
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	sequence s_refused; ds3_valid && !ds3_ready; endsequence
	sequence s_slot(int k); spe_valid && kind == k; endsequence
	property p_refuse; s_refused |=> elastic_overflow; endproperty
	property p_answer; spe_valid |-> $past(spe_ready); endproperty
	property p_poh; spe_valid |-> spe_poh == (cur < 8); endproperty
	property p_filler; s_slot(0) |-> !spe_bit; endproperty
	property p_ctrl; s_slot(1) |-> spe_bit == !row_sopp_data; endproperty
	property p_junk; s_slot(3) ##0 !row_sopp_data |-> !spe_bit; endproperty
	property p_decide; $changed(row_sopp_data) |-> spe_valid && cur == 0; endproperty
	property p_first; spe_first |-> spe_poh && pos_r == 0; endproperty
	a_refuse: assert property (p_refuse) else $error("no overflow pulse");
	a_answer: assert property (p_answer) else $error("unrequested bit");
	a_poh: assert property (p_poh) else $error("overhead slot wrong");
	a_filler: assert property (p_filler) else $error("filler not zero");
	a_ctrl: assert property (p_ctrl) else $error("control bit wrong");
	a_junk: assert property (p_junk) else $error("junk bit not zero");
	a_decide: assert property (p_decide) else $error("decision off row start");
	a_first: assert property (p_first) else $error("envelope start misplaced");
endmodule

bind ds3_spe_mapper ds3_map_chk u_chk (.ref_clk, .sys_rst, .ds3_valid, .ds3_ready, .spe_ready, .spe_bit,
	.spe_valid, .spe_poh, .spe_first, .row_sopp_data, .elastic_overflow);

/* verif/spe_demap_model.sv */
// far end model: paces envelope bits and demaps ds3 bits
`timescale 1ns/1ps
module spe_demap_model (
	input  wire logic ref_clk,
	input  wire logic stall,
	input  wire logic spe_bit,
	input  wire logic spe_valid,
	input  wire logic spe_first,
	output logic      spe_ready = 1'b0,
	output logic      rec_bit,
	output logic      rec_valid,
	output logic      opp_valid,
	output logic      opp_data
);
	int pos = 0;
	int ones = 0;
	int p;
	// ====
	// requests change only off the sampling edge
	always @(negedge ref_clk)
		spe_ready <= !stall;
	// majority of five control bits, so up to two flipped bits are tolerated
	always @(posedge ref_clk)
	begin
		rec_valid <= 1'b0;
		opp_valid <= 1'b0;
		if (spe_valid)
		begin
			p = spe_first ? 0 : pos;
			pos = (p + 1) % 696;
			if (p == 0)
				ones = 0;
			if (p == 26 || p == 248 || p == 249 || p == 480 || p == 481)
				ones += spe_bit;
			opp_valid <= p == 487;
			opp_data <= ones < 3;
			rec_bit <= spe_bit;
			rec_valid <= p > 26 && p < 232 || p > 255 && p < 464 || p > 487 || p == 487 && ones < 3;
		end
	end
endmodule

/* verif/tb_top.sv */
// self-checking bench for the ds3 envelope mapper
`timescale 1ns/1ps
module tb_top;
	logic        ref_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        ds3_bit = 1'b0;
	logic        ds3_valid = 1'b0;
	logic        stall = 1'b1;
	logic        ds3_ready, spe_ready, spe_bit, spe_valid, spe_poh, spe_first, row_sopp_data;
	logic        elastic_overflow, elastic_underrun, rec_bit, rec_valid, opp_valid, opp_data, go;
	logic        ovf_due = 1'b0;
	logic [31:0] seed = 32'h000069ec;
	logic        q[$];
	int          fail_count = 0;
	int          checks_done = 0;
	int          cyc = 0;
	int          acc = -200448;   // holds back the 32 bits the flood put above the mark
	int          rate = 5592;
	int          ndata = 0;
	int          nenv = 0;
	// ====
	// design, far end and clock
	ds3_spe_mapper dut (.ref_clk, .sys_rst, .ds3_bit, .ds3_valid, .ds3_ready, .spe_ready, .spe_bit, .spe_valid,
		.spe_poh, .spe_first, .row_sopp_data, .elastic_overflow, .elastic_underrun);
	spe_demap_model far (.ref_clk, .stall, .spe_bit, .spe_valid, .spe_first, .spe_ready, .rec_bit,
		.rec_valid, .opp_valid, .opp_data);
	always #12.5 ref_clk = ~ref_clk;
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// ====
	// early flood overfills the store; later bits come at a slot-locked rate
	always @(negedge ref_clk)
	begin
		seed = xs(seed);
		cyc++;
		// a refused offer pulses overflow one cycle on; the store never runs dry
		check({elastic_underrun, elastic_overflow}, {1'b0, ovf_due});
		if (spe_ready)
			acc += rate;
		go = cyc > 4 && (cyc < 100 || acc >= 6264 && ds3_ready);
		ovf_due = go && !ds3_ready;
		if (go && ds3_ready)
			q.push_back(seed[8]);
		if (go && cyc >= 100)
			acc -= 6264;
		ds3_bit <= seed[8];
		ds3_valid <= go;
		stall <= cyc < 100 || nenv < 2 && seed[2:0] == 3'h0;
		if (rec_valid)
			check(rec_bit, q.size() ? q.pop_front() : 1'bx);
		if (opp_valid)
			ndata += opp_data;
		if (spe_first)
		begin
			if (nenv == 3 || nenv == 4)
				check(ndata, 3);
			if (nenv > 6)
				check(ndata, 4);
			ndata = 0;
			nenv++;
		end
	end
	// reset, nominal rate, then one surplus bit per envelope
	initial
	begin
		repeat (2) @(negedge ref_clk);
		sys_rst = 1'b0;
		wait (nenv == 5);
		rate = 5593;
		wait (nenv == 9);
		wrap_up();
	end
	// hang guard, well past nine envelopes
	initial
	begin
		#1750000;
		fail_count++;
		wrap_up();
	end
endmodule
